//--- common/hmlc_pkg.sv
// constants and types shared by the hardware monitor limit core
package hmlc_pkg;

   // ****************************************
   // register addresses
   // ****************************************
   localparam logic [7:0] ADDR_CFG   = 8'h00;
   localparam logic [7:0] ADDR_ISR1  = 8'h01;
   localparam logic [7:0] ADDR_ISR2  = 8'h02;
   localparam logic [7:0] ADDR_IMR1  = 8'h03;
   localparam logic [7:0] ADDR_IMR2  = 8'h04;
   localparam logic [7:0] ADDR_FDIV  = 8'h05;
   localparam logic [7:0] ADDR_OSCFG = 8'h06;
   localparam logic [7:0] ADDR_FPOL  = 8'h07;
   localparam logic [7:0] ADDR_RAM   = 8'h20;
   localparam logic [7:0] ADDR_RAM_HI = 8'h3F;

   // ****************************************
   // values after reset
   // ****************************************
   localparam logic [7:0] CFG_RST   = 8'h08;
   localparam logic [7:0] FDIV_RST  = 8'h14;
   localparam logic [7:0] OSCFG_RST = 8'h01;

   // ****************************************
   // field positions
   // ****************************************
   localparam int CFG_START   = 0;
   localparam int CFG_INT_EN  = 1;
   localparam int CFG_INT_CLR = 3;
   localparam int CFG_PULSE   = 4;
   localparam int CFG_INIT    = 7;
   localparam int FDIV_FAIL1  = 0;
   localparam int FDIV_DIV1   = 2;
   localparam int FDIV_DIV2   = 4;
   localparam int FDIV_RO_EN  = 6;
   localparam int FDIV_RO_OS  = 7;
   localparam int OSCFG_RES12 = 3;
   localparam int IMR2_INT_OFF = 6;
   localparam int IMR2_RO_OFF  = 7;
   // status positions in the 16-bit {isr2,isr1} word
   localparam int ST_FAN_ONE_INPUT = 6;
   localparam int ST_IN6  = 8;
   localparam int ST_TEMP = 9;
   localparam int ST_BTI  = 10;
   localparam int ST_CI   = 11;
   localparam int ST_OS   = 12;

   // ****************************************
   // value ram layout (index from 20h)
   // ****************************************
   localparam logic [4:0] RAM_TEMP    = 5'h07;
   localparam logic [4:0] RAM_FAN_ONE_INPUT    = 5'h08;
   localparam logic [4:0] RAM_IN_LIM  = 5'h0A;
   localparam logic [4:0] RAM_T_HI    = 5'h18;
   localparam logic [4:0] RAM_OS_HI   = 5'h1A;
   localparam logic [4:0] RAM_FAN_LIM = 5'h1C;
   localparam logic [3:0] SEQ_LAST    = 4'h9;
   localparam logic [7:0] FAN_FULL    = 8'hFF;

   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_HZ     = 20_000_000;
   localparam int T_VOLT_MS  = 112;
   localparam int T_T12_MS   = 900;
   localparam int T_FAN_MS   = 200;
   localparam int T_PULSE_MS = 10;
   localparam int FAN_CLK_HZ = 22_500;
   localparam int VOLT_CYC   = (CLK_HZ / 1000) * T_VOLT_MS;
   localparam int T12_CYC    = (CLK_HZ / 1000) * T_T12_MS;
   localparam int FAN_CYC    = (CLK_HZ / 1000) * T_FAN_MS;
   localparam int PULSE_CYC  = (CLK_HZ / 1000) * T_PULSE_MS;
   localparam logic [15:0] FAN_TICK_CYC = 16'(CLK_HZ / FAN_CLK_HZ);

   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_CONV = 2'b01,
      SEQ_CMP  = 2'b10
   } hmlc_seq_t;

endpackage

//--- design/hmlc_top.sv
// hardware monitor limit core: link port, sequencer, value ram and limit checks
// How it works
// - each supply input arrives as an unsigned 8-bit code, 10 mV per step
// - temperature is two's complement, 9-bit or 12-bit per resolution bit
// - each fan input works as tachometer or as a failure level input
// - failure level polarity is selectable per fan
// - tachometer period is counted, slower fan gives a larger count
// - fan count is 8 bits and sticks at 255
// - fan count tick is scaled by a programmable divisor
// - fan divisor register: bits 0-5 fan settings, bits 6-7 reset/overtemp output
// - overtemp config low three bits hold shutdown setup, bit 3 selects 12-bit
// - in 12-bit mode overtemp config bits 4-7 show the temperature low bits
// - value ram is 32 bytes at 20h-3Fh: ten results, twenty limits, two spare
// - once started the sequence repeats continuously
// - each new value is checked against its limits and sets a status bit
// - two status registers, one bit per limit check or outside event
// - mask registers per source plus one mask per hardware output
// - reset/overtemp output follows overtemp status or the config pulse, interrupt follows all
// - fan divisor register enables the reset/overtemp output
// - one loop is one temperature, seven voltages and two fan readings
// - slots: 112 ms voltage or 9-bit temp, 900 ms 12-bit temp, 200 ms fan
// - board temperature alert input sets its own status bit
// - order: temperature, inputs 0 to 6, fan one, fan two
// - config bit 0 starts the loop, clearing it stops and shuts down
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// link side, runs on the link clock
// ****************************************
module hmlc_link
   import hmlc_pkg::*;
(
   input  wire logic       i_link_clk,
   input  wire logic       i_link_rst,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   input  wire logic [7:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_ack_tgl,
   input  wire logic [7:0] i_core_rdata,
   output logic            o_req_tgl,
   output logic [7:0]      o_addr,
   output logic [7:0]      o_wdata,
   output logic            o_we,
   output logic            o_busy,
   output logic [7:0]      o_rdata,
   output logic            o_done
);
   typedef struct packed {
      logic       req_tgl;
      logic [2:0] ack_s;
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       we;
      logic       busy;
      logic [7:0] rdata;
      logic       done;
   } hmlc_link_t;

   hmlc_link_t s;
   hmlc_link_t n;

   always_comb begin
      n = s;
      n.done = 1'b0;
      n.ack_s = {s.ack_s[1:0], i_ack_tgl};
      // request words stay still while busy, so the core may read them directly
      if (!s.busy && (i_wr || i_rd)) begin
         n.busy = 1'b1;
         n.addr = i_addr;
         n.wdata = i_wdata;
         n.we = i_wr;
         n.req_tgl = ~s.req_tgl;
      end
      if (s.busy && (s.ack_s[1] ^ s.ack_s[2])) begin
         n.busy = 1'b0;
         n.rdata = i_core_rdata;
         n.done = 1'b1;
      end
      if (i_link_rst) begin
         n = '0;
      end
   end

   always_ff @(posedge i_link_clk) begin
      s <= n;
   end

   assign o_req_tgl = s.req_tgl;
   assign o_addr = s.addr;
   assign o_wdata = s.wdata;
   assign o_we = s.we;
   assign o_busy = s.busy;
   assign o_rdata = s.rdata;
   assign o_done = s.done;

   a_link_done: assert property (@(posedge i_link_clk) disable iff (i_link_rst)
      s.done |-> !s.busy && $past(s.busy))
      else $error("link done without a pending request");
endmodule

// ****************************************
// core, runs on i_clk
// ****************************************
module hmlc_top
   import hmlc_pkg::*;
#(
   parameter int VOLT_SLOT_CYC = VOLT_CYC,
   parameter int T12_SLOT_CYC  = T12_CYC,
   parameter int FAN_SLOT_CYC  = FAN_CYC,
   parameter int PULSE_LEN_CYC = PULSE_CYC
) (
   input  wire logic            i_clk,
   input  wire logic            i_rst,
   input  wire logic            i_link_clk,
   input  wire logic            i_link_rst,
   input  wire logic            i_link_wr,
   input  wire logic            i_link_rd,
   input  wire logic [7:0]      i_link_addr,
   input  wire logic [7:0]      i_link_wdata,
   output logic                 o_link_busy,
   output logic [7:0]           o_link_rdata,
   output logic                 o_link_done,
   input  wire logic [6:0][7:0] i_analog_supply_inputs,
   input  wire logic [11:0]     i_temp_code,
   input  wire logic            i_fan_one_input,
   input  wire logic            i_fan_two_input,
   input  wire logic            i_board_temp_alert_input_n,
   input  wire logic            i_case_intrusion_input,
   output logic                 o_int_n,
   output logic                 o_reset_or_overtemp_output_n
);
   typedef struct packed {
      logic [31:0][7:0] ram;
      logic [7:0]       cfg;
      logic [15:0]      isr;
      logic [15:0]      imr;
      logic [7:0]       fdiv;
      logic [7:0]       oscfg;
      logic [7:0]       fpol;
      logic [2:0]       req_s;
      logic [1:0][2:0]  fan_s;
      logic [1:0]       bti_s;
      logic [1:0]       ci_s;
      hmlc_seq_t        state;
      logic [3:0]       idx;
      logic [31:0]      timer;
      logic             farmed;
      logic [15:0]      ftick;
      logic [7:0]       fcnt;
      logic [7:0]       res;
      logic [31:0]      pulse;
      logic             ack_tgl;
      logic [7:0]       rdata;
      logic             int_n;
      logic             ro_n;
   } hmlc_core_t;

   hmlc_core_t s;
   hmlc_core_t n;
   logic       req_tgl;
   logic [7:0] req_addr;
   logic [7:0] req_wdata;
   logic       req_we;

   hmlc_link u_link (
      .i_link_clk  (i_link_clk),
      .i_link_rst  (i_link_rst),
      .i_wr        (i_link_wr),
      .i_rd        (i_link_rd),
      .i_addr      (i_link_addr),
      .i_wdata     (i_link_wdata),
      .i_ack_tgl   (s.ack_tgl),
      .i_core_rdata(s.rdata),
      .o_req_tgl   (req_tgl),
      .o_addr      (req_addr),
      .o_wdata     (req_wdata),
      .o_we        (req_we),
      .o_busy      (o_link_busy),
      .o_rdata     (o_link_rdata),
      .o_done      (o_link_done)
   );

   // ram index of the result for a sequence slot
   function automatic logic [4:0] res_loc(input logic [3:0] idx);
      if (idx == 4'h0) return RAM_TEMP;
      if (idx <= 4'h7) return 5'(idx - 4'h1);
      return 5'(idx);
   endfunction

   // status position for a sequence slot
   function automatic int stat_pos(input logic [3:0] idx);
      if (idx == 4'h0) return ST_TEMP;
      if (idx == 4'h7) return ST_IN6;
      if (idx <= 4'h6) return int'(idx) - 1;
      return ST_FAN_ONE_INPUT + int'(idx) - 8;
   endfunction

   logic        req_edge;
   logic        init;
   logic        running;
   logic        slot_done;
   logic [7:0]  rd_mux;
   logic [4:0]  ridx;
   logic [4:0]  lim;
   logic        fsel;
   logic        flev;
   logic        frise;
   logic [15:0] tick_lim;
   logic        irq_any;
   logic        ro_act;

   always_comb begin
      n = s;
      slot_done = 1'b0;
      ridx = req_addr[4:0];
      lim = '0;
      fsel = (s.idx == SEQ_LAST);
      flev = s.fan_s[fsel][1];
      frise = s.fan_s[fsel][1] & ~s.fan_s[fsel][2];
      tick_lim = FAN_TICK_CYC << (fsel ? s.fdiv[FDIV_DIV2 +: 2] : s.fdiv[FDIV_DIV1 +: 2]);
      n.req_s = {s.req_s[1:0], req_tgl};
      n.fan_s[0] = {s.fan_s[0][1:0], i_fan_one_input};
      n.fan_s[1] = {s.fan_s[1][1:0], i_fan_two_input};
      n.bti_s = {s.bti_s[0], i_board_temp_alert_input_n};
      n.ci_s = {s.ci_s[0], i_case_intrusion_input};
      req_edge = s.req_s[1] ^ s.req_s[2];
      init = 1'b0;
      n.cfg[CFG_PULSE] = 1'b0;
      if (s.pulse != 32'h0) n.pulse = s.pulse - 32'h1;
      // ****************************************
      // register access from the link
      // ****************************************
      case (req_addr)
         ADDR_CFG:   rd_mux = s.cfg;
         ADDR_ISR1:  rd_mux = s.isr[7:0];
         ADDR_ISR2:  rd_mux = s.isr[15:8];
         ADDR_IMR1:  rd_mux = s.imr[7:0];
         ADDR_IMR2:  rd_mux = s.imr[15:8];
         ADDR_FDIV:  rd_mux = s.fdiv;
         ADDR_OSCFG: rd_mux = s.oscfg;
         ADDR_FPOL:  rd_mux = s.fpol;
         default:    rd_mux = (req_addr >= ADDR_RAM && req_addr <= ADDR_RAM_HI) ?
                              s.ram[ridx] : 8'h00;
      endcase
      if (req_edge) begin
         n.ack_tgl = ~s.ack_tgl;
         if (!req_we) begin
            n.rdata = rd_mux;
            // status clears on read; hardware sets below win over it
            if (req_addr == ADDR_ISR1) n.isr[7:0] = 8'h00;
            if (req_addr == ADDR_ISR2) n.isr[15:8] = 8'h00;
         end else begin
            case (req_addr)
               ADDR_CFG: begin
                  n.cfg = req_wdata & 8'h7F;
                  init = req_wdata[CFG_INIT];
                  if (req_wdata[CFG_PULSE]) n.pulse = 32'(PULSE_LEN_CYC);
               end
               ADDR_IMR1:  n.imr[7:0] = req_wdata;
               ADDR_IMR2:  n.imr[15:8] = req_wdata;
               ADDR_FDIV:  n.fdiv = req_wdata;
               ADDR_OSCFG: n.oscfg[3:0] = req_wdata[3:0];
               ADDR_FPOL:  n.fpol = req_wdata;
               default: begin
                  if (req_addr >= ADDR_RAM && req_addr <= ADDR_RAM_HI) n.ram[ridx] = req_wdata;
               end
            endcase
         end
      end
      // ****************************************
      // measurement sequencer
      // ****************************************
      running = s.cfg[CFG_START] && !s.cfg[CFG_INT_CLR];
      case (s.state)
         SEQ_IDLE: begin
            if (running) begin
               n.state = SEQ_CONV;
               n.idx = 4'h0;
               n.timer = '0;
               n.farmed = 1'b0;
            end
         end
         SEQ_CONV: begin
            n.timer = s.timer + 32'h1;
            if (s.idx == 4'h0) begin
               slot_done = s.timer >=
                           32'((s.oscfg[OSCFG_RES12] ? T12_SLOT_CYC : VOLT_SLOT_CYC) - 1);
               n.res = i_temp_code[11:4];
            end else if (s.idx <= 4'h7) begin
               slot_done = s.timer >= 32'(VOLT_SLOT_CYC - 1);
               n.res = i_analog_supply_inputs[s.idx - 4'h1];
            end else if (s.fdiv[FDIV_FAIL1 + 32'(fsel)]) begin
               // failure indicator: full count when the active level is seen
               slot_done = 1'b1;
               n.res = (flev == s.fpol[fsel]) ? FAN_FULL : 8'h00;
            end else if (!s.farmed) begin
               n.res = FAN_FULL;
               slot_done = s.timer >= 32'(FAN_SLOT_CYC - 1);
               if (frise) begin
                  n.farmed = 1'b1;
                  n.fcnt = 8'h00;
                  n.ftick = 16'h0;
               end
            end else begin
               // period of one tach pulse; two per turn assumed
               n.ftick = s.ftick + 16'h1;
               if (s.ftick >= tick_lim - 16'h1) begin
                  n.ftick = 16'h0;
                  if (s.fcnt != FAN_FULL) n.fcnt = s.fcnt + 8'h1;
               end
               n.res = s.fcnt;
               slot_done = frise || s.timer >= 32'(FAN_SLOT_CYC - 1);
               if (!frise && s.timer >= 32'(FAN_SLOT_CYC - 1)) n.res = FAN_FULL;
            end
            if (slot_done) begin
               n.state = SEQ_CMP;
               n.ram[res_loc(s.idx)] = n.res;
               if (s.idx == 4'h0) begin
                  n.oscfg[7:4] = s.oscfg[OSCFG_RES12] ? i_temp_code[3:0] :
                                 {i_temp_code[3], 3'b000};
               end
            end
         end
         SEQ_CMP: begin
            if (s.idx == 4'h0) begin
               if ($signed(s.res) > $signed(s.ram[RAM_T_HI])) n.isr[ST_TEMP] = 1'b1;
               if ($signed(s.res) > $signed(s.ram[RAM_OS_HI])) n.isr[ST_OS] = 1'b1;
            end else if (s.idx <= 4'h7) begin
               lim = 5'(RAM_IN_LIM + 5'((s.idx - 4'h1) << 1));
               if (s.res > s.ram[lim] || s.res < s.ram[lim + 5'h1]) n.isr[stat_pos(s.idx)] = 1'b1;
            end else begin
               lim = 5'(RAM_FAN_LIM + 5'(fsel));
               if (s.res > s.ram[lim]) n.isr[stat_pos(s.idx)] = 1'b1;
            end
            n.state = SEQ_CONV;
            n.timer = '0;
            n.farmed = 1'b0;
            n.idx = (s.idx == SEQ_LAST) ? 4'h0 : s.idx + 4'h1;
         end
         default: n.state = SEQ_IDLE;
      endcase
      if (!running) n.state = SEQ_IDLE;
      // outside events
      if (!s.bti_s[1]) n.isr[ST_BTI] = 1'b1;
      if (s.ci_s[1]) n.isr[ST_CI] = 1'b1; // latched outside
      // ****************************************
      // hardware outputs
      // ****************************************
      irq_any = |(s.isr & ~s.imr & 16'h1FFF);
      n.int_n = ~(irq_any && s.cfg[CFG_INT_EN] && !s.cfg[CFG_INT_CLR]
                  && !s.imr[8 + IMR2_INT_OFF]);
      // overtemp status reaches this pin in overtemp mode, else the config bit 4 pulse
      ro_act = s.fdiv[FDIV_RO_OS] ? (s.isr[ST_OS] && !s.imr[ST_OS]) : (s.pulse != 32'h0);
      n.ro_n = ~(s.fdiv[FDIV_RO_EN] && !s.imr[8 + IMR2_RO_OFF] && ro_act);
      if (i_rst) begin
         n = '0;
         n.bti_s = 2'b11; // idle level of the alert pin, so no false alert after reset
      end
      if (i_rst || init) begin
         // init keeps the ram and the synchronisers
         n.cfg = CFG_RST;
         n.isr = '0;
         n.imr = '0;
         n.fdiv = FDIV_RST;
         n.oscfg = OSCFG_RST;
         n.fpol = '0;
         n.state = SEQ_IDLE;
         n.pulse = '0;
         n.int_n = 1'b1;
         n.ro_n = 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      s <= n;
   end

   assign o_int_n = s.int_n;
   assign o_reset_or_overtemp_output_n = s.ro_n;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   a_int_enable: assert property (!s.cfg[CFG_INT_EN] |=> o_int_n)
      else $error("interrupt output active while disabled");
   a_fan_sat: assert property (
      s.state == SEQ_CONV && s.farmed && s.fcnt == FAN_FULL |=> s.fcnt == FAN_FULL)
      else $error("fan count left full scale");
   a_seq_step: assert property (s.state == SEQ_CMP && s.idx != SEQ_LAST && running
      |=> s.state == SEQ_CONV && s.idx == $past(s.idx) + 4'h1)
      else $error("sequence did not advance by one");
   a_seq_wrap: assert property (s.state == SEQ_CMP && s.idx == SEQ_LAST && running
      |=> s.idx == 4'h0)
      else $error("sequence did not wrap to temperature");
   a_stop_idle: assert property (!running |=> s.state == SEQ_IDLE)
      else $error("loop still running after stop");
   a_res_stored: assert property (
      s.state == SEQ_CMP |-> s.ram[res_loc(s.idx)] == s.res)
      else $error("result not in value ram at compare");
   a_volt_slot: assert property (s.state == SEQ_CONV && s.idx inside {[4'h1:4'h7]}
      |-> s.timer < 32'(VOLT_SLOT_CYC))
      else $error("voltage slot overran");
   a_volt_flag: assert property (s.state == SEQ_CMP && s.idx inside {[4'h1:4'h7]}
      && s.res > s.ram[RAM_IN_LIM + 5'((s.idx - 4'h1) << 1)]
      |=> s.isr[stat_pos($past(s.idx))])
      else $error("high limit violation not flagged");
   a_bti_flag: assert property (!s.bti_s[1] |=> s.isr[ST_BTI])
      else $error("board alert not flagged");
   a_os_only: assert property (
      s.fdiv[FDIV_RO_OS] && !s.isr[ST_OS] |=> o_reset_or_overtemp_output_n)
      else $error("overtemp output without overtemp status");

   c_wrap: cover property (s.state == SEQ_CMP && s.idx == SEQ_LAST);
   c_fan_tach: cover property (s.state == SEQ_CONV && s.farmed && frise);
   c_int: cover property (!o_int_n);
   c_os: cover property (s.fdiv[FDIV_RO_OS] && !o_reset_or_overtemp_output_n);
endmodule
`default_nettype wire

//--- dv/hmlc_host_model.sv
// host model that drives the link register port of the monitor core
`timescale 1ns/1ps
`default_nettype none
module hmlc_host_model (
   input  wire logic       i_link_clk,
   input  wire logic       i_busy,
   input  wire logic       i_done,
   output logic            o_wr,
   output logic            o_rd,
   output logic [7:0]      o_addr,
   output logic [7:0]      o_wdata,
   output logic            o_is_rd,
   output logic            o_timeout
);
   initial begin
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = 8'h00;
      o_wdata = 8'h00;
      o_is_rd = 1'b0;
      o_timeout = 1'b0;
   end

   // ****************************************
   // one byte access, held until taken
   // ****************************************
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(negedge i_link_clk);
      while (i_busy !== 1'b0 && n < 50) begin
         @(negedge i_link_clk);
         n++;
      end
      if (n >= 50) begin
         o_timeout = 1'b1;
      end
      o_wr = w;
      o_rd = ~w;
      o_addr = a;
      o_wdata = d;
      o_is_rd = ~w;
      @(negedge i_link_clk);
      // released lines show inverted data, never the old value
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = ~a;
      o_wdata = ~d;
      n = 0;
      while (i_done !== 1'b1 && n < 50) begin
         @(negedge i_link_clk);
         n++;
      end
      if (n >= 50) begin
         o_timeout = 1'b1;
      end
   endtask
endmodule
`default_nettype wire

//--- dv/test_hardware_monitor_limit_core.sv
// self-checking bench for the hardware monitor limit core
`timescale 1ns/1ps
`default_nettype none
module test_hardware_monitor_limit_core
   import hmlc_pkg::*;
;
   localparam int PULSE = 10;
   localparam logic [7:0] RA [9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h10};
   localparam logic [7:0] RE [9] = '{8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h14, 8'h01, 8'h00, 8'h00};
   localparam int FAN_PER = 3000;
   logic            i_clk, i_rst, i_link_clk, i_link_rst, link_wr, link_rd, busy, done, is_rd, tmo;
   logic            tach_on = 1'b0;
   int              fan_ph = 0;
   logic [7:0]      addr, wdata, rdata;
   logic [6:0][7:0] ana;
   logic [11:0]     temp;
   logic            fan_one_input, fan_two_input, bti_n, ci, int_n, ro_n;
   int              n_mismatch = 0;
   int              checks = 0;
   int              lo_len = 0;
   int              n_pulse = 0;
   logic [7:0]      exp_q[$];
   string           name_q[$];

   hmlc_top #(.VOLT_SLOT_CYC(20), .T12_SLOT_CYC(40), .FAN_SLOT_CYC(30000), .PULSE_LEN_CYC(PULSE))
   u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_link_clk(i_link_clk), .i_link_rst(i_link_rst),
      .i_link_wr(link_wr), .i_link_rd(link_rd), .i_link_addr(addr), .i_link_wdata(wdata),
      .o_link_busy(busy), .o_link_rdata(rdata), .o_link_done(done),
      .i_analog_supply_inputs(ana), .i_temp_code(temp), .i_fan_one_input(fan_one_input),
      .i_fan_two_input(fan_two_input), .i_board_temp_alert_input_n(bti_n),
      .i_case_intrusion_input(ci), .o_int_n(int_n), .o_reset_or_overtemp_output_n(ro_n));

   hmlc_host_model u_host (.i_link_clk(i_link_clk), .i_busy(busy), .i_done(done), .o_wr(link_wr),
      .o_rd(link_rd), .o_addr(addr), .o_wdata(wdata), .o_is_rd(is_rd), .o_timeout(tmo));

   // ****************************************
   // clocks, checks and closing
   // ****************************************
   initial begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end
   initial begin
      i_link_clk = 1'b0;
      #7;
      forever #32 i_link_clk = ~i_link_clk;
   end

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic complete_run;
      if (n_mismatch == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e);
      name_q.push_back(nm);
      exp_q.push_back(e);
      u_host.xfer(1'b0, a, 8'h00);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      u_host.xfer(1'b1, a, d);
   endtask

   // read data is due with the done pulse; looked at mid-cycle, clear of the launching edge
   always @(negedge i_link_clk) begin
      if (done === 1'b1 && is_rd === 1'b1) begin
         if (exp_q.size() == 0) begin
            n_mismatch++;
            $display("[FAIL] read data expected none seen %h", rdata);
         end else begin
            check(name_q.pop_front(), rdata, exp_q.pop_front());
         end
      end
   end

   always @(negedge i_clk) begin
      if (ro_n === 1'b0) begin
         lo_len++;
      end else if (lo_len != 0) begin
         n_pulse++;
         check("pulse len", 8'(lo_len), 8'(PULSE));
         lo_len = 0;
      end
   end

   // tach source of fixed period, two pulses per turn as the fan promises
   always @(negedge i_clk) begin
      fan_ph <= (fan_ph == FAN_PER - 1) ? 0 : fan_ph + 1;
      fan_one_input <= tach_on && (fan_ph < FAN_PER / 2);
   end

   always @(posedge tmo) begin
      n_mismatch++;
      complete_run();
   end

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      void'($urandom(92536));
      i_rst = 1'b1;
      i_link_rst = 1'b1;
      foreach (ana[i]) ana[i] = 8'(1 + $urandom % 255);
      temp = 12'h100 | 12'($urandom & 32'h6FF);
      fan_two_input = 1'b1;
      bti_n = 1'b1;
      ci = 1'b0;
      repeat (4) @(posedge i_clk);
      @(negedge i_clk);
      i_rst = 1'b0;
      i_link_rst = 1'b0;
      for (int i = 0; i < 9; i++) rd("reset reg", RA[i], RE[i]);
      wr(ADDR_FDIV, 8'h43);
      rd("fdiv", ADDR_FDIV, 8'h43);
      wr(ADDR_OSCFG, 8'h09);
      wr(8'h3A, 8'h7F);
      rd("os limit", 8'h3A, 8'h7F);
      @(negedge i_clk);
      bti_n = 1'b0;
      ci = 1'b1; // outside latch holds the event
      wr(ADDR_CFG, 8'h03);
      repeat (600) @(negedge i_clk);
      check("int out", {7'h00, int_n}, 8'h00);
      bti_n = 1'b1;
      ci = 1'b0;
      wr(ADDR_CFG, 8'h02);
      for (int i = 0; i < 7; i++) rd("volt", 8'(32 + i), ana[i]);
      rd("temp", 8'h27, temp[11:4]);
      rd("fan_one_input", 8'h28, 8'hFF);
      rd("fan_two_input", 8'h29, 8'h00);
      rd("oscfg", ADDR_OSCFG, {temp[3:0], 4'h9});
      rd("isr1", ADDR_ISR1, 8'h7F);
      rd("isr2", ADDR_ISR2, 8'h0F);
      rd("isr1 again", ADDR_ISR1, 8'h00);
      repeat (4) @(negedge i_clk);
      check("int idle", {7'h00, int_n}, 8'h01);
      wr(ADDR_CFG, 8'h10);
      repeat (40) @(negedge i_clk);
      check("pulses", 8'(n_pulse), 8'h01);
      // fan one on tach, divisor code 0; its limit equals the count, so no flag
      wr(ADDR_FDIV, 8'h02);
      wr(8'h3C, 8'h03);
      tach_on = 1'b1;
      wr(ADDR_CFG, 8'h01);
      repeat (7000) @(negedge i_clk);
      wr(ADDR_CFG, 8'h00);
      rd("fan_one_input tach", 8'h28, 8'(FAN_PER / int'(FAN_TICK_CYC)));
      rd("isr1 fan", ADDR_ISR1, 8'h3F);
      complete_run();
   end
endmodule
`default_nettype wire
